// ==== rtl/dcsp_regs.svh ====
// register offsets, field positions and reset values of the dual channel serial port
// assumes byte addressing with one 32-bit word per register
`ifndef DCSP_REGS_SVH
`define DCSP_REGS_SVH

`define DCSP_OFS_CTRL     8'h00
`define DCSP_OFS_DIV      8'h04
`define DCSP_OFS_DATA_A   8'h08
`define DCSP_OFS_DATA_B   8'h0C

`define DCSP_B_EN_A       0
`define DCSP_B_WORD_LENGTH_FIELD_LO    4
`define DCSP_B_WORD_LENGTH_FIELD_HI    8
`define DCSP_B_HALFWORD_MERGE_ENABLE       9
`define DCSP_B_SERIAL_CLOCK_INTERNAL       10
`define DCSP_B_OPERATING_FORMAT_SELECT     11
`define DCSP_B_SAMPLE_EDGE_SELECT       12
`define DCSP_B_FSR        13
`define DCSP_B_IFS        14
`define DCSP_B_SYNC_BUFFER_INDEPENDENT       15
`define DCSP_B_LFS        16
`define DCSP_B_SYNC_LATE_SELECT       17
`define DCSP_B_DMA_A      18
`define DCSP_B_CHN_A      19
`define DCSP_B_DMA_B      20
`define DCSP_B_CHN_B      21
`define DCSP_B_BOTH       22
`define DCSP_B_BHD        23
`define DCSP_B_EN_B       24
`define DCSP_B_TRAN       25
`define DCSP_CTRL_W       26

`define DCSP_CTRL_RST     26'h0
`define DCSP_DIV_RST      32'h0020_0001
`define DCSP_CDIV_LO      0
`define DCSP_CDIV_HI      15
`define DCSP_FPER_LO      16
`define DCSP_FPER_HI      31

`define DCSP_FILL_EMPTY   2'h0
`define DCSP_FILL_PART    2'h2
`define DCSP_FILL_FULL    2'h3
`define DCSP_CNT_FULL     2'h2

`define DCSP_LEN_MAX      6'h20
`define DCSP_LEN_MIN_STD  6'h03
`define DCSP_LEN_MIN_I2S  6'h08

`endif

// ==== rtl/dcsp_pkg.sv ====
// types of the dual channel serial port: pin bundles and the module state
// assumes dcsp_regs.svh for all numeric constants
package dcsp_pkg;

   typedef struct packed {
      logic       sclk;
      logic       fs;
      logic [1:0] dat;
   } dcsp_pin_in_s;

   typedef struct packed {
      logic       sclk;
      logic       sclk_oe;
      logic       fs;
      logic       fs_oe;
      logic [1:0] dat;
      logic [1:0] dat_oe;
   } dcsp_pin_out_s;

   typedef enum logic {ENG_IDLE, ENG_SHIFT} dcsp_eng_e;

   typedef struct packed {
      logic [25:0]           ctrl;
      logic [31:0]           div;
      logic [31:0]           rdata;
      logic                  stall;
      logic                  stall_rd;
      logic                  stall_ch;
      logic [1:0][1:0][31:0] mem;
      logic [1:0][1:0]       cnt;
      logic [1:0]            rptr;
      logic [1:0]            wptr;
      logic [1:0]            err;
      logic [1:0][15:0]      hold;
      logic                  half;
      logic [1:0][31:0]      shreg;
      logic [3:0]            sy1;
      logic [3:0]            sy2;
      logic                  sclk_int;
      logic                  clk_prev;
      logic [15:0]           dcnt;
      logic [15:0]           fcnt;
      dcsp_eng_e             eng;
      logic                  armed;
      logic [5:0]            bitcnt;
      logic                  fs_prev;
      logic                  started;
      logic                  fs_drv;
      logic                  pend;
      logic                  pend_ch;
      logic [31:0]           pend_data;
      dcsp_pin_out_s         pins;
      logic [1:0]            dma_req;
      logic [1:0]            chain;
   } dcsp_state_s;

endpackage

// ==== rtl/dcsp_ctrl.sv ====
// control, buffers and serial engine of a two-channel synchronous serial port
// assumes one system clock; link pins are asynchronous and pass two flip-flops
`timescale 1ns/10ps
`include "dcsp_regs.svh"

module dcsp_ctrl #(
   parameter int AW = 8
) (
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire logic [AW-1:0]          addr,
   input  wire logic [31:0]            wdata,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic [31:0]                 rdata,
   output logic                        core_stall,
   input  wire dcsp_pkg::dcsp_pin_in_s pins_in,
   output dcsp_pkg::dcsp_pin_out_s     pins_out,
   output logic [1:0]                  dma_req,
   output logic [1:0]                  chain_en
);
   import dcsp_pkg::*;

   dcsp_state_s s;
   dcsp_state_s n;

   function automatic logic [5:0] eff_len(logic [4:0] f, logic i2s_m);
      logic [5:0] l;
      l = (f == 5'h00) ? `DCSP_LEN_MAX : {1'b0, f};
      if (i2s_m && l < `DCSP_LEN_MIN_I2S) begin
         l = `DCSP_LEN_MIN_I2S;
      end else if (l < `DCSP_LEN_MIN_STD) begin
         l = `DCSP_LEN_MIN_STD;
      end
      return l;
   endfunction

   function automatic logic [1:0] fill_code(logic [1:0] c);
      if (c == 2'h0) begin
         return `DCSP_FILL_EMPTY;
      end else if (c == `DCSP_CNT_FULL) begin
         return `DCSP_FILL_FULL;
      end
      return `DCSP_FILL_PART;
   endfunction

   // msb-first bit of the word, or of its current half when packing
   function automatic logic tx_bit(logic [31:0] w, logic pk, logic hf,
                                   logic [5:0] len, logic [5:0] idx);
      logic [31:0] src;
      logic [5:0]  k;
      src = pk ? {16'h0000, (hf ? w[31:16] : w[15:0])} : w;
      k   = len - 6'h01 - idx;
      return src[k[4:0]];
   endfunction

   logic       i2s;
   logic       lj;
   logic       tx;
   logic       int_clk;
   logic       int_fs;
   logic       lfs;
   logic       late;
   logic       sync_required;
   logic       halfword_merge_enable;
   logic       stall_disable;
   logic [1:0] en;
   logic [5:0] len;
   logic       lvl;
   logic       samp;
   logic       drv;
   logic       fs_act;
   logic [1:0] ok_c;
   logic       gate;

   assign i2s     = s.ctrl[`DCSP_B_OPERATING_FORMAT_SELECT];
   assign lj      = s.ctrl[`DCSP_B_SYNC_LATE_SELECT];
   assign tx      = s.ctrl[`DCSP_B_TRAN];
   assign int_clk = s.ctrl[`DCSP_B_SERIAL_CLOCK_INTERNAL];
   assign int_fs  = i2s ? s.ctrl[`DCSP_B_SERIAL_CLOCK_INTERNAL] : s.ctrl[`DCSP_B_IFS];
   assign lfs     = ~i2s & s.ctrl[`DCSP_B_LFS];
   assign late    = i2s ? lj : s.ctrl[`DCSP_B_SYNC_LATE_SELECT];
   assign sync_required     = i2s | s.ctrl[`DCSP_B_FSR];
   assign halfword_merge_enable    = s.ctrl[`DCSP_B_HALFWORD_MERGE_ENABLE];
   assign stall_disable     = s.ctrl[`DCSP_B_BHD];
   assign en      = {s.ctrl[`DCSP_B_EN_B], s.ctrl[`DCSP_B_EN_A]};
   assign len     = eff_len(s.ctrl[`DCSP_B_WORD_LENGTH_FIELD_HI:`DCSP_B_WORD_LENGTH_FIELD_LO], i2s);

   // clock level and its edges, seen from the system clock
   assign lvl  = int_clk ? s.sclk_int : s.sy2[3];
   assign samp = (i2s | s.ctrl[`DCSP_B_SAMPLE_EDGE_SELECT]) ? (lvl & ~s.clk_prev)
                                              : (~lvl & s.clk_prev);
   assign drv  = (i2s | s.ctrl[`DCSP_B_SAMPLE_EDGE_SELECT]) ? (~lvl & s.clk_prev)
                                              : (lvl & ~s.clk_prev);
   assign fs_act = int_fs ? s.fs_drv : (s.sy2[2] ^ lfs);

   // buffer condition that lets a data-dependent sync go out
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         ok_c[c] = tx ? (s.cnt[c] != 2'h0) : (s.cnt[c] != `DCSP_CNT_FULL);
      end
   end
   assign gate = s.ctrl[`DCSP_B_SYNC_BUFFER_INDEPENDENT]
              | ((&en & s.ctrl[`DCSP_B_BOTH]) ? (&ok_c)
                                               : (|(ok_c & en)));

   always_comb begin
      logic        ch;
      logic        start;
      logic        word_end;
      logic [31:0] word;
      logic [15:0] per;
      ch       = 1'b0;
      start    = 1'b0;
      word_end = 1'b0;
      word     = 32'h0;
      per      = s.div[`DCSP_FPER_HI:`DCSP_FPER_LO];
      n        = s;
      n.rdata  = 32'h0;
      n.sy1    = {pins_in.sclk, pins_in.fs, pins_in.dat};
      n.sy2    = s.sy1;
      n.clk_prev = lvl;

      // internal serial clock from the divider
      if (int_clk) begin
         if (s.dcnt >= s.div[`DCSP_CDIV_HI:`DCSP_CDIV_LO]) begin
            n.dcnt     = 16'h0000;
            n.sclk_int = ~s.sclk_int;
         end else begin
            n.dcnt = s.dcnt + 16'h0001;
         end
      end

      // sampling edge: take data bits and look for the frame sync
      if (samp) begin
         n.fs_prev = fs_act;
         if (s.eng == ENG_SHIFT) begin
            for (int c = 0; c < 2; c++) begin
               n.shreg[c] = {s.shreg[c][30:0], s.sy2[c]};
            end
         end
         if (i2s) begin
            start = (fs_act != s.fs_prev)
                  & (s.started | (fs_act == (lj ? ~s.ctrl[`DCSP_B_LFS]
                                               : s.ctrl[`DCSP_B_LFS])));
         end else begin
            start = fs_act & ~s.fs_prev;
         end
         if (start) begin
            n.started = 1'b1;
            if (late) begin
               n.eng    = ENG_SHIFT;
               n.bitcnt = 6'h00;
               for (int c = 0; c < 2; c++) begin
                  n.shreg[c] = {31'h0, s.sy2[c]};
                  if (en[c] && (tx ? s.cnt[c] == 2'h0 : s.cnt[c] == `DCSP_CNT_FULL)) begin
                     n.err[c] = 1'b1;
                  end
               end
            end else begin
               n.armed = 1'b1;
            end
         end
      end

      // driving edge: close words, start armed words, make syncs
      if (drv) begin
         word_end = (s.eng == ENG_SHIFT) && (s.bitcnt == len - 6'h01);
         if (s.eng == ENG_SHIFT && !word_end) begin
            n.bitcnt = s.bitcnt + 6'h01;
         end
         if (word_end) begin
            for (int c = 0; c < 2; c++) begin
               if (en[c] && tx && (!halfword_merge_enable || s.half) && n.cnt[c] != 2'h0) begin
                  n.rptr[c] = ~n.rptr[c];
                  n.cnt[c]  = n.cnt[c] - 2'h1;
               end
               if (en[c] && !tx) begin
                  if (halfword_merge_enable && !s.half) begin
                     n.hold[c] = s.shreg[c][15:0];
                  end else begin
                     word = halfword_merge_enable ? {s.shreg[c][15:0], s.hold[c]} : s.shreg[c];
                     if (n.cnt[c] == `DCSP_CNT_FULL) begin
                        n.mem[c][~n.wptr[c]] = word;
                     end else begin
                        n.mem[c][n.wptr[c]] = word;
                        n.wptr[c] = ~n.wptr[c];
                        n.cnt[c]  = n.cnt[c] + 2'h1;
                     end
                  end
               end
            end
            if (halfword_merge_enable) begin
               n.half = ~s.half;
            end
            n.eng    = sync_required ? ENG_IDLE : ENG_SHIFT;
            n.bitcnt = 6'h00;
         end
         if (s.armed || (word_end && !sync_required)) begin
            n.armed  = 1'b0;
            n.eng    = ENG_SHIFT;
            n.bitcnt = 6'h00;
            for (int c = 0; c < 2; c++) begin
               n.shreg[c] = 32'h0;
               if (en[c] && (tx ? n.cnt[c] == 2'h0 : n.cnt[c] == `DCSP_CNT_FULL)) begin
                  n.err[c] = 1'b1;
               end
            end
         end
         if (int_fs) begin
            if (i2s) begin
               if (s.fcnt >= {10'h000, len} - 16'h0001) begin
                  n.fcnt   = 16'h0000;
                  n.fs_drv = ~s.fs_drv;
               end else begin
                  n.fcnt = s.fcnt + 16'h0001;
               end
            end else begin
               n.fs_drv = 1'b0;
               if (s.fcnt + 16'h0001 >= per && gate) begin
                  n.fcnt   = 16'h0000;
                  n.fs_drv = 1'b1;
               end else if (s.fcnt + 16'h0001 < per) begin
                  n.fcnt = s.fcnt + 16'h0001;
               end
            end
         end
      end

      // a stalled write completes as soon as its buffer has room
      if (s.pend && n.cnt[s.pend_ch] != `DCSP_CNT_FULL) begin
         n.mem[s.pend_ch][n.wptr[s.pend_ch]] = s.pend_data;
         n.wptr[s.pend_ch] = ~n.wptr[s.pend_ch];
         n.cnt[s.pend_ch]  = n.cnt[s.pend_ch] + 2'h1;
         n.pend  = 1'b0;
         n.stall = 1'b0;
      end
      if (s.stall && s.stall_rd && n.cnt[s.stall_ch] != 2'h0) begin
         n.stall    = 1'b0;
         n.stall_rd = 1'b0;
      end

      // register port
      ch = (addr == AW'(`DCSP_OFS_DATA_B));
      if (wr_en) begin
         if (addr == AW'(`DCSP_OFS_CTRL)) begin
            n.ctrl = wdata[`DCSP_CTRL_W-1:0];
         end else if (addr == AW'(`DCSP_OFS_DIV)) begin
            n.div = wdata;
         end else if ((addr == AW'(`DCSP_OFS_DATA_A) || ch) && tx && en[ch] && !n.pend) begin
            if (n.cnt[ch] == `DCSP_CNT_FULL) begin
               if (!stall_disable) begin
                  n.stall     = 1'b1;
                  n.stall_rd  = 1'b0;
                  n.stall_ch  = ch;
                  n.pend      = 1'b1;
                  n.pend_ch   = ch;
                  n.pend_data = wdata;
               end
            end else begin
               n.mem[ch][n.wptr[ch]] = wdata;
               n.wptr[ch] = ~n.wptr[ch];
               n.cnt[ch]  = n.cnt[ch] + 2'h1;
            end
         end
      end
      if (rd_en) begin
         if (addr == AW'(`DCSP_OFS_CTRL)) begin
            n.rdata = {fill_code(s.cnt[0]), s.err[0],
                       fill_code(s.cnt[1]), s.err[1], s.ctrl};
         end else if (addr == AW'(`DCSP_OFS_DIV)) begin
            n.rdata = s.div;
         end else if ((addr == AW'(`DCSP_OFS_DATA_A) || ch) && !tx && en[ch]) begin
            if (n.cnt[ch] != 2'h0) begin
               n.rdata    = n.mem[ch][n.rptr[ch]];
               n.rptr[ch] = ~n.rptr[ch];
               n.cnt[ch]  = n.cnt[ch] - 2'h1;
            end else if (!stall_disable) begin
               n.stall    = 1'b1;
               n.stall_rd = 1'b1;
               n.stall_ch = ch;
            end
         end
      end

      // a disabled channel is reinitialised
      for (int c = 0; c < 2; c++) begin
         if (!n.ctrl[c == 0 ? `DCSP_B_EN_A : `DCSP_B_EN_B]) begin
            n.cnt[c]  = 2'h0;
            n.rptr[c] = 1'b0;
            n.wptr[c] = 1'b0;
            n.err[c]  = 1'b0;
         end
      end
      if (!(|en)) begin
         n.eng     = ENG_IDLE;
         n.armed   = 1'b0;
         n.bitcnt  = 6'h00;
         n.half    = 1'b0;
         n.fcnt    = 16'h0000;
         n.started = 1'b0;
         n.fs_drv  = 1'b0;
         n.pend    = 1'b0;
         n.stall   = 1'b0;
      end

      // data and sync pin outputs change only on the driving edge
      if (drv) begin
         for (int c = 0; c < 2; c++) begin
            n.pins.dat[c] = tx_bit(n.mem[c][n.rptr[c]], halfword_merge_enable, n.half, len, n.bitcnt);
         end
         n.pins.fs = n.fs_drv ^ lfs;
      end
      n.pins.sclk    = n.sclk_int;
      n.pins.sclk_oe = int_clk & (|en);
      n.pins.fs_oe   = int_fs & (|en);
      n.pins.dat_oe  = tx ? en : 2'h0;
      for (int c = 0; c < 2; c++) begin
         n.dma_req[c] = en[c] & s.ctrl[c == 0 ? `DCSP_B_DMA_A : `DCSP_B_DMA_B]
                      & (tx ? n.cnt[c] != `DCSP_CNT_FULL : n.cnt[c] != 2'h0);
         n.chain[c]   = en[c] & s.ctrl[c == 0 ? `DCSP_B_CHN_A : `DCSP_B_CHN_B];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s      <= '0;
         s.ctrl <= `DCSP_CTRL_RST;
         s.div  <= `DCSP_DIV_RST;
      end else begin
         s <= n;
      end
   end

   assign rdata      = s.rdata;
   assign core_stall = s.stall;
   assign pins_out   = s.pins;
   assign dma_req    = s.dma_req;
   assign chain_en   = s.chain;

endmodule

// ==== sim/dcsp_ctrl_props.sv ====
// assertions on the ports of the dual channel serial port controller
// assumes a bind into dcsp_ctrl; the shadow mirrors software control writes
`timescale 1ns/10ps

module dcsp_ctrl_props #(
   parameter int AW = 8
) (
   input wire logic                    sys_clk,
   input wire logic                    reset_n,
   input wire logic [AW-1:0]           addr,
   input wire logic [31:0]             wdata,
   input wire logic                    wr_en,
   input wire logic                    rd_en,
   input wire logic [31:0]             rdata,
   input wire logic                    core_stall,
   input wire dcsp_pkg::dcsp_pin_in_s  pins_in,
   input wire dcsp_pkg::dcsp_pin_out_s pins_out,
   input wire logic [1:0]              dma_req,
   input wire logic [1:0]              chain_en
);
   import dcsp_pkg::*;
   logic [25:0] shadow;
   logic [1:0]  chain_calc;
   logic [1:0]  dma_ok;
   logic        acc;
   logic        unmapped;
   assign chain_calc = {shadow[21] & shadow[24], shadow[19] & shadow[0]};
   assign dma_ok     = {shadow[20] & shadow[24], shadow[18] & shadow[0]};
   assign acc        = wr_en | rd_en;
   assign unmapped   = (addr[AW-1:4] != '0) || (addr[1:0] != 2'b00);
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         shadow <= 26'h0;
      end else if (wr_en && addr == '0) begin
         shadow <= wdata[25:0];
      end
   end
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   a_ctrl_readback: assert property (
      rd_en && addr == '0 |=> rdata[25:0] == $past(shadow))
      else $error("control readback differs");
   a_fill_code: assert property (
      rd_en && addr == '0 |=> rdata[31:30] != 2'b01 && rdata[28:27] != 2'b01)
      else $error("illegal fill code");
   a_unmapped_zero: assert property (
      rd_en && unmapped |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_chain_follow: assert property (
      $stable(chain_calc) [*2] |-> chain_en == chain_calc)
      else $error("chain enable wrong");
   a_dma_gate: assert property (
      (dma_req & ~dma_ok & ~$past(dma_ok)) == 2'b00)
      else $error("dma request while disabled");
   a_idle_no_drive: assert property (
      (!shadow[0] && !shadow[24]) [*3] |->
      {pins_out.sclk_oe, pins_out.fs_oe, pins_out.dat_oe} == 4'h0)
      else $error("pins driven while channels off");
   a_rx_dat_off: assert property (
      (!shadow[25]) [*3] |-> pins_out.dat_oe == 2'b00)
      else $error("data driven in receive");
   a_ext_clock: assert property (
      (!shadow[10]) [*3] |-> !pins_out.sclk_oe)
      else $error("clock driven while external");
   a_ext_sync: assert property (
      (!shadow[14] && !shadow[11]) [*3] |-> !pins_out.fs_oe)
      else $error("sync driven while external");
   a_stall_cause: assert property (
      $rose(core_stall) |-> !shadow[23] && ($past(acc) || $past(acc, 2)))
      else $error("stall without access or with stall disable");

   c_stall: cover property ($rose(core_stall));
   c_error: cover property (rd_en && addr == '0 ##1 rdata[29]);
   c_dma: cover property (dma_req != 2'b00);
   c_int_sync: cover property (pins_out.fs_oe && pins_out.fs);
endmodule

bind dcsp_ctrl dcsp_ctrl_props #(.AW(AW)) u_props (
   .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .core_stall(core_stall),
   .pins_in(pins_in), .pins_out(pins_out), .dma_req(dma_req), .chain_en(chain_en)
);

// ==== sim/dcsp_codec.sv ====
// behavioural external codec on the serial link: clock, early sync, data
// assumes rising sample edge in the port; the clock stands low between frames
`timescale 1ns/10ps

module dcsp_codec (
   input  wire dcsp_pkg::dcsp_pin_out_s pins_out,
   output dcsp_pkg::dcsp_pin_in_s       pins_in
);
   import dcsp_pkg::*;
   logic        clk_l;
   logic        fs_l;
   logic [1:0]  dat_l;
   logic [31:0] got;
   initial begin
      clk_l = 1'b0;
      fs_l  = 1'b0;
      dat_l = 2'b00;
      got   = 32'h0;
   end
   // wired level: whichever party enables its driver wins
   assign pins_in = '{sclk: pins_out.sclk_oe ? pins_out.sclk : clk_l,
                      fs:   pins_out.fs_oe ? pins_out.fs : fs_l,
                      dat:  (pins_out.dat & pins_out.dat_oe) | (dat_l & ~pins_out.dat_oe)};

   // one word of len bits, MSB first; sync one clock before the first bit
   task automatic frame(input int len, input logic [31:0] tx_a, input logic [31:0] tx_b);
      got = 32'h0;
      fs_l = 1'b1;
      #400 clk_l = 1'b1;
      for (int i = 0; i <= len; i++) begin
         #400;
         // sample late in the high phase, where the port's data is settled
         if (i > 0) got = {got[30:0], pins_in.dat[0]};
         clk_l = 1'b0;
         fs_l  = 1'b0;
         if (i < len) dat_l = {tx_b[len-1-i], tx_a[len-1-i]};
         #400 clk_l = 1'b1;
      end
      #400 clk_l = 1'b0;
      dat_l = ~dat_l;
   endtask
endmodule

// ==== sim/dcsp_ctrl_test.sv ====
// self-checking bench of the dual channel serial port controller
// assumes dcsp_codec on the link pins and the checker bound to the design
`timescale 1ns/10ps

module dcsp_ctrl_test;
   import dcsp_pkg::*;
   logic          sys_clk;
   logic          reset_n;
   logic [7:0]    addr;
   logic [31:0]   wdata;
   logic          wr_en;
   logic          rd_en;
   logic [31:0]   rdata;
   logic          core_stall;
   dcsp_pin_in_s  pins_in;
   dcsp_pin_out_s pins_out;
   logic [1:0]    dma_req;
   logic [1:0]    chain_en;
   logic [31:0]   v;
   int            mismatches;
   int            cmp_count;
   int            cycles = 0;

   dcsp_ctrl #(.AW(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .core_stall(core_stall), .pins_in(pins_in), .pins_out(pins_out),
      .dma_req(dma_req), .chain_en(chain_en));
   dcsp_codec codec (.pins_out(pins_out), .pins_in(pins_in));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic finish_test;
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic t_regs;
      rd(8'h00);
      chk("ctrl reset", 32'h0, v);
      rd(8'h04);
      chk("divisor reset", 32'h0020_0001, v);
      rd(8'h10);
      chk("unmapped", 32'h0, v);
      wr(8'h00, 32'hFEFF_FFFE);
      rd(8'h00);
      chk("ctrl rw", 32'h02FF_FFFE, v);
      wr(8'h00, 32'h0);
   endtask
   task automatic t_dma;
      wr(8'h00, 32'h0324_0001);
      repeat (3) @(posedge sys_clk);
      #1 chk("dma a", 32'h1, {30'h0, dma_req});
      chk("chain b", 32'h2, {30'h0, chain_en});
      wr(8'h00, 32'h0318_0001);
      repeat (3) @(posedge sys_clk);
      #1 chk("dma b", 32'h2, {30'h0, dma_req});
      chk("chain a", 32'h1, {30'h0, chain_en});
      wr(8'h00, 32'h0);
   endtask
   task automatic t_tx;
      wr(8'h00, 32'h0200_3081);
      wr(8'h08, 32'hA5);
      wr(8'h08, 32'h3C);
      rd(8'h00);
      chk("fill full", 32'h3, {30'h0, v[31:30]});
      wr(8'h08, 32'h77);
      repeat (2) @(posedge sys_clk);
      #1 chk("stall", 32'h1, {31'h0, core_stall});
      codec.frame(8, 32'h0, 32'h0);
      chk("tx word", 32'hA5, {24'h0, codec.got[7:0]});
      repeat (8) @(posedge sys_clk);
      #1 chk("stall gone", 32'h0, {31'h0, core_stall});
      rd(8'h00);
      chk("tx status", 32'h6, {29'h0, v[31:29]});
      wr(8'h00, 32'h0);
   endtask
   task automatic t_rx;
      wr(8'h00, 32'h0080_3081);
      rd(8'h08);
      chk("empty read", 32'h0, v);
      @(posedge sys_clk);
      #1 chk("no stall", 32'h0, {31'h0, core_stall});
      codec.frame(8, 32'h5A, 32'h0);
      rd(8'h08);
      chk("rx word", 32'h5A, v);
      codec.frame(8, 32'h11, 32'h0);
      codec.frame(8, 32'h22, 32'h0);
      codec.frame(8, 32'h33, 32'h0);
      rd(8'h00);
      chk("rx overflow", 32'h7, {29'h0, v[31:29]});
      rd(8'h08);
      chk("rx oldest", 32'h11, v);
      rd(8'h08);
      chk("rx overwrite", 32'h33, v);
      wr(8'h00, 32'h0);
   endtask
   task automatic t_underflow;
      wr(8'h00, 32'h0300_3081);
      codec.frame(8, 32'h0, 32'h0);
      rd(8'h00);
      chk("underflow", 32'h09, {26'h0, v[31:26]});
      wr(8'h00, 32'h0300_3081);
      rd(8'h00);
      chk("sticky", 32'h09, {26'h0, v[31:26]});
      wr(8'h00, 32'h0);
      rd(8'h00);
      chk("reinit", 32'h0, v);
   endtask
   // internal clock and data-independent sync; divisor at reset gives a four-cycle serial
   // clock and a sync of one serial clock every 32 serial clocks
   task automatic t_internal;
      logic [31:0] hi_fs;
      logic [31:0] hi_clk;
      hi_fs  = 32'h0;
      hi_clk = 32'h0;
      wr(8'h00, 32'h0200_D481);
      repeat (200) @(posedge sys_clk);
      #1 chk("int drivers", 32'h3, {30'h0, pins_out.sclk_oe, pins_out.fs_oe});
      repeat (128) begin
         @(posedge sys_clk);
         #1;
         hi_clk = hi_clk + {31'h0, pins_out.sclk};
         hi_fs  = hi_fs + {31'h0, pins_out.fs};
      end
      chk("clock high", 32'h40, hi_clk);
      chk("sync high", 32'h4, hi_fs);
      rd(8'h00);
      chk("free run underflow", 32'h1, {29'h0, v[31:29]});
      wr(8'h00, 32'h0);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         finish_test;
      end
   end
   initial begin
      reset_n    = 1'b0;
      addr       = 8'h0;
      wdata      = 32'h0;
      wr_en      = 1'b0;
      rd_en      = 1'b0;
      mismatches = 0;
      cmp_count  = 0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs;
      t_dma;
      t_tx;
      t_rx;
      t_underflow;
      t_internal;
      finish_test;
   end
endmodule
